// *** pll_reference_clock_select_tb.sv ***
`timescale 1ns/1ns
module pll_reference_clock_select_tb;
  logic sys_clk_in = 0, rst_b_in = 0, ssel = 0, dyn = 0, usel = 0, dd = 0;
  logic den = 0, cpk = 0, stop = 0, m_arm = 0, m_cp = 0, m_st = 0, e;
  logic ref_o, st, dpo, dpoe, dpin;
  logic [1:0] fs = 0, cd = 0, ce = 0, m_fs = 0, cpo, cpoe, cpin;
  logic [3:0] uc = 0, ud = 0, up = 0, ctl = 0, m_gp = 0, pins, gp, net, xn;
  logic [31:0] lf = 32'h6C973E9D;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  pllrs_clock_select uut (.sys_clk_in, .rst_b_in,
    .dedicated_clk_pin_in(pins), .cfg_first_sel_in(fs),
    .cfg_second_sel_in(ssel), .cfg_dynamic_en_in(dyn), .user_ref_sel_in(usel),
    .pll_reference_input_out(ref_o), .ref_sel_state_out(st),
    .cfg_net_use_ctrl_in(uc), .cfg_net_use_dual_in(ud), .cfg_net_pin_in(up),
    .cfg_net_side_in(8'h1B), .ctrl_sig_in(ctl), .global_net_out(net),
    .dual_purpose_clock_pin_in(dpin), .dual_purpose_clock_pin_out(dpo),
    .dual_purpose_clock_pin_oe_b_out(dpoe), .dual_drive_in(dd),
    .dual_drive_en_in(den), .corner_dual_purpose_clock_pin_in(cpin),
    .corner_dual_purpose_clock_pin_out(cpo),
    .corner_dual_purpose_clock_pin_oe_b_out(cpoe), .corner_io_drive_in(cd),
    .corner_io_en_in(ce), .cfg_corner_pick_in(cpk), .clk_pin_gp_data_out(gp));
  pllrs_far_side far (.sys_clk_in, .stop_in(stop), .pin_out(pins),
    .dp_oe_b_in(dpoe), .dp_in(dpo), .dp_out(dpin), .cp_oe_b_in(cpoe),
    .cp_in(cpo), .cp_out(cpin));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk_ref(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected ref at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic chk_gp(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected gp at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic chk_net(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected net at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // the model reads pre-edge values, like the flops it mirrors
  always @(posedge sys_clk_in) begin
    m_st = rst_b_in & (dyn ? usel : ssel);
    m_gp = rst_b_in ? pins : 4'h0;
    if (!rst_b_in) {m_arm, m_cp, m_fs} = 4'h0;
    else if (!m_arm) {m_arm, m_cp, m_fs} = {1'b1, cpk, fs};
    lf = lfsr(lf);
    {fs, cd, ce, ssel, dyn, dd, den, cpk} <= lf[10:0];
    {uc, ud, up, ctl} <= lf[27:12];
    if (cyc % 8 == 0) usel <= lf[28];
    cyc++;
    stop <= cyc > 200 && cyc < 300;
    rst_b_in <= !(cyc < 6 || cyc == 400);
    if (cyc == 600) wrap_up();
  end
  always @(negedge sys_clk_in) if (rst_b_in) begin
    e = dyn ? usel : ssel;
    for (int n = 0; n < 4; n++)
      xn[n] = ud[n] ? (up[n] ? cpin[m_cp] : dpin) : uc[n] ? ctl[n] : pins[n];
    chk_ref({ref_o, st}, {pins[{e, m_fs[e]}], m_st});
    chk_gp(gp, m_gp);
    chk_net(net, xn);
  end
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
endmodule

// *** pllrs_clock_select.sv ***
// Operation
// - pll reference input taken from one of four pins in two stages
// - two first-stage muxes reduce four pins to two clocks
// - first-stage selects come only from configuration bits
// - second stage 2-to-1, select from config bit or user logic
// - each global network has its own clock control block on a side
// - dedicated clock pins can drive a clock or control signal
// - dual-purpose pins are bidirectional, carry fan-out signals globally
// - only one corner dual-purpose pin of a pair feeds control block
// - unused dedicated clock pin is plain input, captured by logic regs
`timescale 1ns/1ns
`include "pllrs_defines.svh"
module pllrs_clock_select
  import pllrs_pkg::*;
#(
  parameter int NETS = `PLLRS_NUM_GLOBAL_NETS
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] dedicated_clk_pin_in,
  input wire logic [1:0] cfg_first_sel_in,
  input wire logic cfg_second_sel_in,
  input wire logic cfg_dynamic_en_in,
  input wire logic user_ref_sel_in,
  output logic pll_reference_input_out,
  output logic ref_sel_state_out,
  input wire logic [NETS-1:0] cfg_net_use_ctrl_in,
  input wire logic [NETS-1:0] cfg_net_use_dual_in,
  input wire logic [NETS-1:0] cfg_net_pin_in,
  input wire logic [NETS*2-1:0] cfg_net_side_in,
  input wire logic [NETS-1:0] ctrl_sig_in,
  output logic [NETS-1:0] global_net_out,
  input wire logic dual_purpose_clock_pin_in,
  output logic dual_purpose_clock_pin_out,
  output logic dual_purpose_clock_pin_oe_b_out,
  input wire logic dual_drive_in,
  input wire logic dual_drive_en_in,
  input wire logic [1:0] corner_dual_purpose_clock_pin_in,
  output logic [1:0] corner_dual_purpose_clock_pin_out,
  output logic [1:0] corner_dual_purpose_clock_pin_oe_b_out,
  input wire logic [1:0] corner_io_drive_in,
  input wire logic [1:0] corner_io_en_in,
  input wire logic cfg_corner_pick_in,
  output logic [3:0] clk_pin_gp_data_out
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // one 2-to-1 cell shared by both stages and the dual-source pick
  function automatic logic mux2(input logic sel, input logic in0,
                                input logic in1);
    mux2 = sel ? in1 : in0;
  endfunction

  // ------------------------------------------------------------
  // configuration capture
  // ------------------------------------------------------------
  // first-stage selects are latched once after reset so that later
  // wiggles on the configuration inputs cannot reach the pll path
  logic [1:0] first_sel_reg;
  logic [1:0] first_sel_next;
  logic cfg_done_reg;
  logic cfg_done_next;
  logic corner_pick_reg;
  logic corner_pick_next;

  always_comb begin
    first_sel_next = first_sel_reg;
    corner_pick_next = corner_pick_reg;
    cfg_done_next = 1'h1;
    if (!cfg_done_reg) begin
      first_sel_next = cfg_first_sel_in;
      corner_pick_next = cfg_corner_pick_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      first_sel_reg <= {2{`PLLRS_FIRST_SEL_RST}};
      corner_pick_reg <= `PLLRS_CORNER_PICK_RST;
      cfg_done_reg <= `PLLRS_CFG_DONE_RST;
    end else begin
      first_sel_reg <= first_sel_next;
      corner_pick_reg <= corner_pick_next;
      cfg_done_reg <= cfg_done_next;
    end
  end

  // ------------------------------------------------------------
  // first stage
  // ------------------------------------------------------------
  // pins 0/1 feed clock a, pins 2/3 feed clock b; selects are frozen
  logic [1:0] stage1_clk;

  assign stage1_clk[0] = mux2(first_sel_reg[0], dedicated_clk_pin_in[0],
                              dedicated_clk_pin_in[1]);
  assign stage1_clk[1] = mux2(first_sel_reg[1], dedicated_clk_pin_in[2],
                              dedicated_clk_pin_in[3]);

  // ------------------------------------------------------------
  // second stage
  // ------------------------------------------------------------
  // dynamic select acts directly; no glitch guard, user keeps it stable
  logic second_sel;

  assign second_sel = mux2(cfg_dynamic_en_in, cfg_second_sel_in,
                           user_ref_sel_in);
  assign pll_reference_input_out = mux2(second_sel, stage1_clk[0],
                                        stage1_clk[1]);

  // ------------------------------------------------------------
  // select status
  // ------------------------------------------------------------
  // a registered copy lets user logic see which clock the pll is on
  logic ref_sel_reg;
  logic ref_sel_next;

  always_comb begin
    ref_sel_next = second_sel;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_sel_reg <= `PLLRS_SECOND_SEL_RST;
    end else begin
      ref_sel_reg <= ref_sel_next;
    end
  end

  assign ref_sel_state_out = ref_sel_reg;

  // ------------------------------------------------------------
  // corner dual-purpose pin pair
  // ------------------------------------------------------------
  // the picked pin is never driven, so the network sees only the board
  logic corner_feed;

  assign corner_feed = corner_dual_purpose_clock_pin_in[corner_pick_reg];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      // the picked corner pin is input only; the other is plain io
      corner_dual_purpose_clock_pin_out[i] = corner_io_drive_in[i];
      corner_dual_purpose_clock_pin_oe_b_out[i] =
        !(corner_io_en_in[i] && (corner_pick_reg != 1'(i)));
    end
  end

  // ------------------------------------------------------------
  // dual-purpose pin
  // ------------------------------------------------------------
  assign dual_purpose_clock_pin_out = dual_drive_in;
  assign dual_purpose_clock_pin_oe_b_out = !dual_drive_en_in;

  // ------------------------------------------------------------
  // clock control blocks, one per global network
  // ------------------------------------------------------------
  // dual source outranks a control signal when both are configured
  function automatic pllrs_gsrc_e net_source(input logic use_dual,
                                             input logic use_ctrl);
    net_source = PLLRS_GSRC_CLOCK;
    if (use_dual) begin
      net_source = PLLRS_GSRC_DUAL;
    end else if (use_ctrl) begin
      net_source = PLLRS_GSRC_CTRL;
    end
  endfunction

  // side only places the block; the routing is identical on each side
  pllrs_side_e net_side [NETS];
  always_comb begin
    for (int n = 0; n < NETS; n++) begin
      net_side[n] = pllrs_side_e'(cfg_net_side_in[n*2 +: 2]);
    end
  end

  pllrs_gsrc_e net_src [NETS];
  always_comb begin
    for (int n = 0; n < NETS; n++) begin
      net_src[n] = net_source(cfg_net_use_dual_in[n],
                              cfg_net_use_ctrl_in[n]);
    end
  end

  always_comb begin
    for (int n = 0; n < NETS; n++) begin
      unique case (net_src[n])
        PLLRS_GSRC_CLOCK: begin
          global_net_out[n] =
            dedicated_clk_pin_in[n % `PLLRS_NUM_CLK_PINS];
        end
        PLLRS_GSRC_CTRL: begin
          global_net_out[n] = ctrl_sig_in[n];
        end
        PLLRS_GSRC_DUAL: begin
          global_net_out[n] = mux2(cfg_net_pin_in[n],
            dual_purpose_clock_pin_in, corner_feed);
        end
        default: begin
          global_net_out[n] = 1'h0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // general-purpose use of clock pins
  // ------------------------------------------------------------
  // no io register on this path, so capture in ordinary logic regs;
  // the cost is one clock of latency before user logic sees a pin
  logic [3:0] gp_data_reg;
  logic [3:0] gp_data_next;
  always_comb begin
    gp_data_next = dedicated_clk_pin_in;
  end
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gp_data_reg <= `PLLRS_GP_DATA_RST;
    end else begin
      gp_data_reg <= gp_data_next;
    end
  end
  assign clk_pin_gp_data_out = gp_data_reg;

endmodule

// *** pllrs_clock_select_monitor.sv ***
`timescale 1ns/1ns
module pllrs_clock_select_monitor (
  input logic sys_clk_in, rst_b_in, cfg_second_sel_in, cfg_dynamic_en_in,
  input logic user_ref_sel_in, cfg_corner_pick_in, pll_reference_input_out,
  input logic ref_sel_state_out, dual_purpose_clock_pin_oe_b_out,
  input logic dual_drive_en_in,
  input logic [3:0] dedicated_clk_pin_in, clk_pin_gp_data_out,
  input logic [1:0] cfg_first_sel_in, corner_io_en_in,
  input logic [1:0] corner_dual_purpose_clock_pin_oe_b_out,
  input logic dual_purpose_clock_pin_out, dual_drive_in,
  input logic [1:0] corner_dual_purpose_clock_pin_out, corner_io_drive_in
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // config is taken once, so later input changes must never show
  logic [3:0] cap_reg;
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) cap_reg <= 4'h0;
    else if (!cap_reg[3])
      cap_reg <= {1'b1, cfg_corner_pick_in, cfg_first_sel_in};
  end
  wire e = cfg_dynamic_en_in ? user_ref_sel_in : cfg_second_sel_in;
  wire cp = cap_reg[2];
  sequence s_swap;
    cfg_dynamic_en_in && $changed(user_ref_sel_in);
  endsequence
  a_ref_pick: assert property (pll_reference_input_out ==
    dedicated_clk_pin_in[{e, cap_reg[e]}]) else $error("ref pick");
  a_sel_state: assert property (1'b1 |=> ref_sel_state_out == $past(e))
    else $error("sel state");
  a_sel_static: assert property (!cfg_dynamic_en_in |=>
    ref_sel_state_out == $past(cfg_second_sel_in)) else $error("static");
  a_ref_switch: assert property (s_swap |=>
    ref_sel_state_out == $past(user_ref_sel_in)) else $error("switch");
  a_gp_capture: assert property (1'b1 |=>
    clk_pin_gp_data_out == $past(dedicated_clk_pin_in)) else $error("gp");
  a_dual_oe: assert property (dual_purpose_clock_pin_oe_b_out ==
    !dual_drive_en_in) else $error("dual oe");
  a_corner_pick: assert property (
    corner_dual_purpose_clock_pin_oe_b_out[cp]) else $error("picked");
  a_corner_io: assert property (corner_io_en_in[!cp] !=
    corner_dual_purpose_clock_pin_oe_b_out[!cp]) else $error("corner io");
  a_dual_drive: assert property (dual_purpose_clock_pin_out ==
    dual_drive_in) else $error("dual drive");
  a_corner_drive: assert property (corner_io_drive_in[!cp] ==
    corner_dual_purpose_clock_pin_out[!cp]) else $error("corner drive");
endmodule
bind pllrs_clock_select pllrs_clock_select_monitor mon (.*);

// *** pllrs_defines.svh ***
`ifndef PLLRS_DEFINES_SVH
`define PLLRS_DEFINES_SVH
// ------------------------------------------------------------
// constants
// ------------------------------------------------------------
`define PLLRS_NUM_CLK_PINS 4
`define PLLRS_NUM_GLOBAL_NETS 4
`define PLLRS_FIRST_SEL_RST 1'h0
`define PLLRS_SECOND_SEL_RST 1'h0
`define PLLRS_CORNER_PICK_RST 1'h0
`define PLLRS_CFG_DONE_RST 1'h0
`define PLLRS_GP_DATA_RST 4'h0
`endif

// *** pllrs_far_side.sv ***
`timescale 1ns/1ns
module pllrs_far_side (
  input wire logic sys_clk_in, stop_in, dp_oe_b_in, dp_in,
  input wire logic [1:0] cp_oe_b_in, cp_in,
  output logic [3:0] pin_out,
  output logic dp_out,
  output logic [1:0] cp_out
);
  logic [3:0] cnt_reg = 4'h0;
  always_ff @(posedge sys_clk_in) cnt_reg <= cnt_reg + 4'h1;
  assign pin_out = {cnt_reg[3:1], cnt_reg[0] & ~stop_in};
  // released pins toggle so a stale level never passes
  assign dp_out = dp_oe_b_in ? cnt_reg[0] : dp_in;
  assign cp_out = (cp_oe_b_in & {2{cnt_reg[1]}}) | (~cp_oe_b_in & cp_in);
endmodule

// *** pllrs_pkg.sv ***
package pllrs_pkg;
  // driver of a global clock network
  typedef enum logic [2:0] {
    PLLRS_GSRC_CLOCK = 3'h1,
    PLLRS_GSRC_CTRL = 3'h2,
    PLLRS_GSRC_DUAL = 3'h4
  } pllrs_gsrc_e;
  // side on which a clock control block sits
  typedef enum logic [1:0] {
    PLLRS_SIDE_TOP = 2'h0,
    PLLRS_SIDE_BOTTOM = 2'h1,
    PLLRS_SIDE_LEFT = 2'h2,
    PLLRS_SIDE_RIGHT = 2'h3
  } pllrs_side_e;
endpackage
